// file: rtl/lddr_pkg.sv
// package: register map, reset values and carriers of the dimming register slice
package lddr_pkg;

    // ------------------------------------------------------------
    // register offsets
    // ------------------------------------------------------------
    localparam logic [7:0] LDDR_CH14_DUTY_UPPER_OFS = 8'h33;
    localparam logic [7:0] LDDR_CH15_ANALOG_LEVEL_OFS = 8'h34;
    localparam logic [7:0] LDDR_CH15_DUTY_LOWER_OFS = 8'h35;
    localparam logic [7:0] LDDR_CH15_DUTY_UPPER_OFS = 8'h36;
    localparam logic [7:0] LDDR_CH16_ANALOG_LEVEL_OFS = 8'h37;
    localparam logic [7:0] LDDR_CH16_DUTY_LOWER_OFS = 8'h38;
    localparam logic [7:0] LDDR_CH16_DUTY_UPPER_OFS = 8'h39;

    // ------------------------------------------------------------
    // field widths and reset values
    // ------------------------------------------------------------
    localparam int LDDR_LEVEL_W = 6;
    localparam int LDDR_LOWER_W = 4;
    localparam int LDDR_UPPER_W = 8;
    localparam int LDDR_DUTY_W = 12;
    localparam int LDDR_FULL_SCALE_W = 8;
    localparam logic [5:0] LDDR_LEVEL_RST = 6'h3f;
    localparam logic [3:0] LDDR_LOWER_RST = 4'hf;
    localparam logic [7:0] LDDR_UPPER_RST = 8'hff;
    localparam logic [11:0] LDDR_DUTY_RST = 12'hfff;
    localparam logic [7:0] LDDR_RDATA_RST = 8'h00;
    localparam logic [7:0] LDDR_CURRENT_RST = 8'h00;
    // full-scale analog code: current = code / 63 * full scale
    localparam logic [13:0] LDDR_LEVEL_FULL = 14'h003f;

    // ------------------------------------------------------------
    // carriers
    // ------------------------------------------------------------
    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } lddr_req_s;

    typedef struct packed {
        logic wr_level;
        logic wr_lower;
        logic wr_upper;
        logic [7:0] wdata;
    } lddr_chan_wr_s;

    typedef struct packed {
        logic [5:0] level;
        logic [3:0] lower;
        logic [7:0] upper;
        logic [11:0] duty;
        logic [7:0] current;
    } lddr_chan_s;

endpackage : lddr_pkg

// file: rtl/lddr_chan.sv
// module: one channel's level, split duty and active duty registers
`timescale 1ns/1ps
`default_nettype none

module lddr_chan (
    // clock and reset
    input wire logic clk_i,
    input wire logic nrst_i,
    // register writes
    input wire lddr_pkg::lddr_chan_wr_s wr_i,
    // full-scale current setting
    input wire logic [lddr_pkg::LDDR_FULL_SCALE_W-1:0] full_scale_current_set_i,
    // channel state
    output lddr_pkg::lddr_chan_s state_o
);

    lddr_pkg::lddr_chan_s state;
    lddr_pkg::lddr_chan_s next_state;
    logic [13:0] product;

    always_comb begin
        next_state = state;
        product = {8'h00, state.level} * {6'h00, full_scale_current_set_i};
        if (wr_i.wr_level) begin
            next_state.level = wr_i.wdata[lddr_pkg::LDDR_LEVEL_W-1:0];
        end
        if (wr_i.wr_lower) begin
            // held aside, not yet active
            next_state.lower = wr_i.wdata[lddr_pkg::LDDR_LOWER_W-1:0];
        end
        if (wr_i.wr_upper) begin
            next_state.upper = wr_i.wdata;
            next_state.duty = {wr_i.wdata, state.lower};
        end
        // linear scaling of the analog code
        next_state.current = 8'(product / lddr_pkg::LDDR_LEVEL_FULL);
    end

    always_ff @(posedge clk_i) begin
        if (!nrst_i) begin
            state.level <= lddr_pkg::LDDR_LEVEL_RST;
            state.lower <= lddr_pkg::LDDR_LOWER_RST;
            state.upper <= lddr_pkg::LDDR_UPPER_RST;
            state.duty <= lddr_pkg::LDDR_DUTY_RST;
            state.current <= lddr_pkg::LDDR_CURRENT_RST;
        end else begin
            state <= next_state;
        end
    end

    assign state_o = state;

endmodule // lddr_chan

`default_nettype wire

// file: rtl/lddr_regs.sv
// module: dimming register slice for channels 14 to 16
//
// How it works
// - level register: 6-bit code, resets all ones
// - current equals code over 63 times full-scale
// - low duty nibble in bits 3:0, resets 1111
// - high duty byte holds bits 11:4, resets ff
// - duty takes effect only on high-byte write
// - channel 15 registers at 0x34, 0x35, 0x36
// - channel 16 registers at 0x37, 0x38, 0x39
// - channel 14 high duty byte at 0x33
`timescale 1ns/1ps
`default_nettype none

module lddr_regs #(
    parameter int NUM_CH = 2
) (
    // clock and reset
    input wire logic clk_i,
    input wire logic nrst_i,
    // register port from the serial host interface
    input wire lddr_pkg::lddr_req_s req_i,
    output logic [7:0] rdata_o,
    // channel 14 low nibble, held by the neighbouring slice
    input wire logic [lddr_pkg::LDDR_LOWER_W-1:0] ch14_duty_lower_i,
    // full-scale current setting
    input wire logic [lddr_pkg::LDDR_FULL_SCALE_W-1:0] full_scale_current_set_i,
    // active dimming settings
    output logic [lddr_pkg::LDDR_DUTY_W-1:0] ch14_duty_code_o,
    output logic [lddr_pkg::LDDR_DUTY_W-1:0] ch15_duty_code_o,
    output logic [lddr_pkg::LDDR_DUTY_W-1:0] ch16_duty_code_o,
    output logic [lddr_pkg::LDDR_LEVEL_W-1:0] ch15_level_code_o,
    output logic [lddr_pkg::LDDR_LEVEL_W-1:0] ch16_level_code_o,
    output logic [lddr_pkg::LDDR_FULL_SCALE_W-1:0] ch15_current_o,
    output logic [lddr_pkg::LDDR_FULL_SCALE_W-1:0] ch16_current_o
);

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    typedef struct packed {
        logic [7:0] ch14_upper;
        logic [11:0] ch14_duty;
        logic [7:0] rdata;
    } lddr_top_s;

    lddr_top_s state;
    lddr_top_s next_state;
    lddr_pkg::lddr_chan_wr_s chan_wr [NUM_CH];
    lddr_pkg::lddr_chan_s chan [NUM_CH];

    localparam logic [7:0] LEVEL_OFS [NUM_CH] = '{
        lddr_pkg::LDDR_CH15_ANALOG_LEVEL_OFS, lddr_pkg::LDDR_CH16_ANALOG_LEVEL_OFS};
    localparam logic [7:0] LOWER_OFS [NUM_CH] = '{
        lddr_pkg::LDDR_CH15_DUTY_LOWER_OFS, lddr_pkg::LDDR_CH16_DUTY_LOWER_OFS};
    localparam logic [7:0] UPPER_OFS [NUM_CH] = '{
        lddr_pkg::LDDR_CH15_DUTY_UPPER_OFS, lddr_pkg::LDDR_CH16_DUTY_UPPER_OFS};

    // ------------------------------------------------------------
    // channels 15 and 16
    // ------------------------------------------------------------
    for (genvar g = 0; g < NUM_CH; g++) begin : g_chan
        always_comb begin
            chan_wr[g].wdata = req_i.wdata;
            chan_wr[g].wr_level = req_i.wr && (req_i.addr == LEVEL_OFS[g]);
            chan_wr[g].wr_lower = req_i.wr && (req_i.addr == LOWER_OFS[g]);
            chan_wr[g].wr_upper = req_i.wr && (req_i.addr == UPPER_OFS[g]);
        end

        lddr_chan u_chan (
            .clk_i(clk_i),
            .nrst_i(nrst_i),
            .wr_i(chan_wr[g]),
            .full_scale_current_set_i(full_scale_current_set_i),
            .state_o(chan[g])
        );
    end

    // ------------------------------------------------------------
    // channel 14 high byte and read path
    // ------------------------------------------------------------
    always_comb begin
        next_state = state;
        if (req_i.wr && (req_i.addr == lddr_pkg::LDDR_CH14_DUTY_UPPER_OFS)) begin
            next_state.ch14_upper = req_i.wdata;
            next_state.ch14_duty = {req_i.wdata, ch14_duty_lower_i};
        end
        if (req_i.rd) begin
            unique case (req_i.addr)
                lddr_pkg::LDDR_CH14_DUTY_UPPER_OFS: next_state.rdata = state.ch14_upper;
                lddr_pkg::LDDR_CH15_ANALOG_LEVEL_OFS: next_state.rdata = {2'h0, chan[0].level};
                lddr_pkg::LDDR_CH15_DUTY_LOWER_OFS: next_state.rdata = {4'h0, chan[0].lower};
                lddr_pkg::LDDR_CH15_DUTY_UPPER_OFS: next_state.rdata = chan[0].upper;
                lddr_pkg::LDDR_CH16_ANALOG_LEVEL_OFS: next_state.rdata = {2'h0, chan[1].level};
                lddr_pkg::LDDR_CH16_DUTY_LOWER_OFS: next_state.rdata = {4'h0, chan[1].lower};
                lddr_pkg::LDDR_CH16_DUTY_UPPER_OFS: next_state.rdata = chan[1].upper;
                default: next_state.rdata = lddr_pkg::LDDR_RDATA_RST;
            endcase
        end
    end

    always_ff @(posedge clk_i) begin
        if (!nrst_i) begin
            state.ch14_upper <= lddr_pkg::LDDR_UPPER_RST;
            state.ch14_duty <= lddr_pkg::LDDR_DUTY_RST;
            state.rdata <= lddr_pkg::LDDR_RDATA_RST;
        end else begin
            state <= next_state;
        end
    end

    // ------------------------------------------------------------
    // outputs, all from flip-flops
    // ------------------------------------------------------------
    assign rdata_o = state.rdata;
    assign ch14_duty_code_o = state.ch14_duty;
    assign ch15_duty_code_o = chan[0].duty;
    assign ch16_duty_code_o = chan[1].duty;
    assign ch15_level_code_o = chan[0].level;
    assign ch16_level_code_o = chan[1].level;
    assign ch15_current_o = chan[0].current;
    assign ch16_current_o = chan[1].current;

endmodule // lddr_regs

`default_nettype wire

// file: test/lddr_regs_props.sv
// checker: port-level properties of the dimming register slice
`timescale 1ns/1ps
`default_nettype none
module lddr_regs_props (
    // watched ports
    input wire logic clk_i,
    input wire logic nrst_i,
    input wire lddr_pkg::lddr_req_s req_i,
    input wire logic [7:0] rdata_o,
    input wire logic [3:0] ch14_duty_lower_i,
    input wire logic [7:0] full_scale_current_set_i,
    input wire logic [11:0] ch14_duty_code_o,
    input wire logic [11:0] ch15_duty_code_o,
    input wire logic [11:0] ch16_duty_code_o,
    input wire logic [5:0] ch15_level_code_o,
    input wire logic [7:0] ch15_current_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (!nrst_i);
    sequence s_wr(a); req_i.wr && req_i.addr == a; endsequence
    sequence s_rd(a); req_i.rd && req_i.addr == a; endsequence
    AST_HOLD15: assert property (!(req_i.wr && req_i.addr == 8'h36)
        |=> $stable(ch15_duty_code_o)) else $error("ch15 duty moved without upper write");
    AST_UP15: assert property (s_wr(8'h36)
        |=> ch15_duty_code_o[11:4] == $past(req_i.wdata)) else $error("ch15 upper wrong");
    AST_UP16: assert property (s_wr(8'h39)
        |=> ch16_duty_code_o[11:4] == $past(req_i.wdata)) else $error("ch16 upper wrong");
    AST_UP14: assert property (s_wr(8'h33) |=> ch14_duty_code_o ==
        {$past(req_i.wdata), $past(ch14_duty_lower_i)}) else $error("ch14 duty wrong");
    AST_LVL15: assert property (s_wr(8'h34) |=> {2'b00, ch15_level_code_o} ==
        ($past(req_i.wdata) & 8'h3f)) else $error("ch15 level wrong");
    AST_RDLVL: assert property (s_rd(8'h34)
        |=> rdata_o == {2'b00, $past(ch15_level_code_o)}) else $error("level readback wrong");
    AST_RDLOW: assert property (s_rd(8'h35)
        |=> rdata_o[7:4] == 4'h0) else $error("lower reserved bits set");
    AST_CUR: assert property (nrst_i && $past(nrst_i) |-> ch15_current_o ==
        8'(({8'h00, $past(ch15_level_code_o)} * $past(full_scale_current_set_i)) / 14'd63))
        else $error("ch15 current wrong");
endmodule // lddr_regs_props
bind lddr_regs lddr_regs_props lddr_regs_props_i (.clk_i, .nrst_i, .req_i, .rdata_o,
    .ch14_duty_lower_i, .full_scale_current_set_i, .ch14_duty_code_o, .ch15_duty_code_o,
    .ch16_duty_code_o, .ch15_level_code_o, .ch15_current_o);
`default_nettype wire

// file: test/lddr_host.sv
// partner: serial host controller issuing register strobes
`timescale 1ns/1ps
`default_nettype none
module lddr_host (
    // clock
    input wire logic clk_i,
    // register requests
    output var lddr_pkg::lddr_req_s req_o
);
    initial req_o = '0;
    // one strobe per call; released address and data inverted, never stale
    task automatic go(input logic w, input logic r, input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_i);
        #1 req_o = {w, r, a, d};
        @(posedge clk_i);
        #1 req_o = {2'b00, ~a, ~d};
    endtask
endmodule // lddr_host
`default_nettype wire

// file: test/tb_lddr_regs.sv
// testbench: dimming register slice for channels 14 to 16
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin error_cnt++; \
    $display("CHECK FAILED %s exp %h got %h", nm, e, g); end end
module tb_lddr_regs;
    logic clk_i = 1'b0;
    logic nrst_i = 1'b0;
    logic [3:0] low14 = 4'h0;
    logic [7:0] fs_set = 8'h00;
    logic [7:0] rdata;
    logic [11:0] duty [3];
    logic [5:0] lvl [2];
    logic [7:0] cur [2];
    lddr_pkg::lddr_req_s req;
    int error_cnt = 0;
    int n_compared = 0;
    always #5 clk_i = ~clk_i;
    lddr_host lddr_host_i (.clk_i(clk_i), .req_o(req));
    lddr_regs lddr_regs_i (.clk_i(clk_i), .nrst_i(nrst_i), .req_i(req), .rdata_o(rdata),
        .ch14_duty_lower_i(low14), .full_scale_current_set_i(fs_set),
        .ch14_duty_code_o(duty[0]), .ch15_duty_code_o(duty[1]), .ch16_duty_code_o(duty[2]),
        .ch15_level_code_o(lvl[0]), .ch16_level_code_o(lvl[1]),
        .ch15_current_o(cur[0]), .ch16_current_o(cur[1]));
    // ----
    // scenarios
    // ----
    task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
        lddr_host_i.go(1'b0, 1'b1, a, 8'h00);
        `CHK("rdata", e, rdata)
    endtask
    task automatic t_reset;
        `CHK("duty14", 12'hfff, duty[0])
        `CHK("level16", 6'h3f, lvl[1])
        rd_chk(8'h35, 8'h0f);
        rd_chk(8'h39, 8'hff);
        rd_chk(8'h37, 8'h3f);
        $display("test reset done");
    endtask
    task automatic t_split;
        logic [7:0] b;
        logic [11:0] e12;
        for (int c = 0; c < 2; c++) begin
            b = 8'h34 + 8'(3 * c);
            lddr_host_i.go(1'b1, 1'b0, b + 8'h1, 8'hfa);
            `CHK("duty held", 12'hfff, duty[c + 1])
            rd_chk(b + 8'h1, 8'h0a);
            lddr_host_i.go(1'b1, 1'b0, b + 8'h2, 8'h5c + 8'(c));
            e12 = {8'h5c + 8'(c), 4'ha};
            `CHK("duty", e12, duty[c + 1])
            rd_chk(b + 8'h2, 8'h5c + 8'(c));
        end
        $display("test split duty done");
    endtask
    task automatic t_ch14;
        low14 = 4'h3;
        lddr_host_i.go(1'b1, 1'b0, 8'h33, 8'ha7);
        `CHK("duty14", 12'ha73, duty[0])
        rd_chk(8'h33, 8'ha7);
        $display("test ch14 done");
    endtask
    task automatic t_level;
        fs_set = 8'h80;
        lddr_host_i.go(1'b1, 1'b0, 8'h34, 8'hd5);
        lddr_host_i.go(1'b1, 1'b0, 8'h37, 8'hc9);
        `CHK("level15", 6'h15, lvl[0])
        `CHK("level16", 6'h09, lvl[1])
        rd_chk(8'h34, 8'h15);
        `CHK("current15", 8'((21 * 128) / 63), cur[0])
        `CHK("current16", 8'((9 * 128) / 63), cur[1])
        $display("test level done");
    endtask
    task automatic t_rerst;
        @(posedge clk_i);
        #1 nrst_i = 1'b0;
        @(posedge clk_i);
        #1 nrst_i = 1'b1;
        `CHK("duty15", 12'hfff, duty[1])
        `CHK("level15", 6'h3f, lvl[0])
        `CHK("rdata", 8'h00, rdata)
        rd_chk(8'h3a, 8'h00);
        `CHK("current15", fs_set, cur[0])
        $display("test reset again done");
    endtask
    task automatic complete_run;
        $display("compared %0d mismatches %0d", n_compared, error_cnt);
        if (error_cnt == 0 && n_compared > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    initial begin
        #20000;
        error_cnt++;
        complete_run();
    end
    initial begin
        repeat (4) @(posedge clk_i);
        #1 nrst_i = 1'b1;
        t_reset();
        t_split();
        t_ch14();
        t_level();
        t_rerst();
        complete_run();
    end
endmodule // tb_lddr_regs
`default_nettype wire
